/* adc_port_pkg.sv */
// Constants for the dual converter parallel output port
package adc_port_pkg;
  localparam int SAMPLE_WIDTH = 14;
  localparam int LSB_POS = 0;
  localparam int MSB_POS = 13;
  localparam int PIPE_LATENCY = 8;
  localparam int LAT_CNT_WIDTH = 4;

  // Register map
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] MASK_OFFSET = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] STATE_OFFSET = 8'h0C;

  localparam int OVR_A_BIT = 0;
  localparam int OVR_B_BIT = 1;
  localparam int SAMPLE_BIT = 2;
  localparam int CTRL_GRAY_BIT = 0;
  localparam int CTRL_PD_BIT = 1;

  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [13:0] WORD_RESET = 14'h0000;

  typedef enum logic [1:0] {
    ST_DOWN  = 2'b00,
    ST_FILL  = 2'b01,
    ST_RUN   = 2'b11
  } conv_state_t;
endpackage

/* sample_delay_line.sv */
// Fixed-latency delay line for packed sample words
`timescale 1ns/1ps
module sample_delay_line #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Stream
  input  wire logic             shift_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] stage [DEPTH];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else if (shift_i) begin
      stage[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign data_o = stage[DEPTH-1];
endmodule

/* dual_adc_output_port.sv */
// Dual-channel converter parallel output port with Wishbone status/control
// Functional notes
// - Channel B word, bit 0 LSB, 13 MSB
// - Channel A word, same bit ordering
// - Channel B out-of-range flag tracks overrange
// - Channel A flag independent of channel B
// - One shared strobe, rising edge marks data
// - Format low two's complement unless the control Gray bit is set, high Gray
// - Output appears eight sample clocks later
// - Power-down high stops both channels
`timescale 1ns/1ps
module dual_adc_output_port (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Sampling clock and raw conversion results
  input  wire logic        sample_clk_i,
  input  wire logic [13:0] chan_a_raw_i,
  input  wire logic        chan_a_ovr_raw_i,
  input  wire logic [13:0] chan_b_raw_i,
  input  wire logic        chan_b_ovr_raw_i,
  // Static pins
  input  wire logic        gray_select_i,
  input  wire logic        power_down_input_i,
  // Parallel output
  output logic      [13:0] chan_a_result_o,
  output logic             chan_a_over_range_o,
  output logic      [13:0] chan_b_result_o,
  output logic             chan_b_over_range_o,
  output logic             sample_valid_strobe_o,
  // Interrupt
  output logic             irq_o
);
  localparam int PACK_W = 2 * adc_port_pkg::SAMPLE_WIDTH + 2;

  function automatic logic [13:0] encode_word(input logic [13:0] w, input logic gray);
    logic [13:0] r;
    r = gray ? (w ^ {1'b0, w[13:1]}) : w;
    return r;
  endfunction

  // Pin synchronisers: first stage read only by second
  logic [1:0] sclk_sync;
  logic [1:0] gray_sync;
  logic [1:0] pd_sync;
  logic [13:0] a_s1, a_s2, b_s1, b_s2;
  logic [1:0] ova_sync, ovb_sync;
  logic sclk_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_sync <= 2'h0;
      gray_sync <= 2'h0;
      pd_sync   <= 2'h0;
      ova_sync  <= 2'h0;
      ovb_sync  <= 2'h0;
      a_s1      <= adc_port_pkg::WORD_RESET;
      a_s2      <= adc_port_pkg::WORD_RESET;
      b_s1      <= adc_port_pkg::WORD_RESET;
      b_s2      <= adc_port_pkg::WORD_RESET;
      sclk_prev <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sample_clk_i};
      gray_sync <= {gray_sync[0], gray_select_i};
      pd_sync   <= {pd_sync[0], power_down_input_i};
      ova_sync  <= {ova_sync[0], chan_a_ovr_raw_i};
      ovb_sync  <= {ovb_sync[0], chan_b_ovr_raw_i};
      a_s1      <= chan_a_raw_i;
      a_s2      <= a_s1;
      b_s1      <= chan_b_raw_i;
      b_s2      <= b_s1;
      sclk_prev <= sclk_sync[1];
    end
  end

  // Rising edge of sampling clock takes a sample
  logic sample_tick;
  assign sample_tick = sclk_sync[1] & ~sclk_prev;

  // Control register
  logic [1:0] control;
  logic       gray_mode;
  logic       powered_down;
  assign gray_mode    = gray_sync[1] | control[adc_port_pkg::CTRL_GRAY_BIT];
  assign powered_down = pd_sync[1] | control[adc_port_pkg::CTRL_PD_BIT];

  logic run_tick;
  assign run_tick = sample_tick & ~powered_down;

  // Both channels travel packed so they stay aligned
  logic [PACK_W-1:0] pack_in;
  logic [PACK_W-1:0] pack_out;
  assign pack_in = {ova_sync[1], a_s2, ovb_sync[1], b_s2};

  sample_delay_line #(
    .WIDTH (PACK_W),
    .DEPTH (adc_port_pkg::PIPE_LATENCY)
  ) u_delay (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .shift_i (run_tick),
    .data_i  (pack_in),
    .data_o  (pack_out)
  );

  // Pipeline fill tracking; strobe only once real data emerges
  adc_port_pkg::conv_state_t state;
  logic [adc_port_pkg::LAT_CNT_WIDTH-1:0] fill_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= adc_port_pkg::ST_DOWN;
      fill_cnt <= '0;
    end else begin
      case (state)
        adc_port_pkg::ST_DOWN: begin
          fill_cnt <= '0;
          if (!powered_down) begin
            state <= adc_port_pkg::ST_FILL;
          end
        end
        adc_port_pkg::ST_FILL: begin
          if (powered_down) begin
            state <= adc_port_pkg::ST_DOWN;
          end else if (run_tick) begin
            if (fill_cnt == adc_port_pkg::LAT_CNT_WIDTH'(adc_port_pkg::PIPE_LATENCY - 1)) begin
              state <= adc_port_pkg::ST_RUN;
            end
            fill_cnt <= fill_cnt + 1'b1;
          end
        end
        adc_port_pkg::ST_RUN: begin
          if (powered_down) begin
            state <= adc_port_pkg::ST_DOWN;
          end
        end
        default: begin
          state <= adc_port_pkg::ST_DOWN;
        end
      endcase
    end
  end

  logic out_tick;
  assign out_tick = run_tick & (state == adc_port_pkg::ST_RUN);

  // Output registers updated together on each output sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_a_result_o     <= adc_port_pkg::WORD_RESET;
      chan_b_result_o     <= adc_port_pkg::WORD_RESET;
      chan_a_over_range_o <= 1'b0;
      chan_b_over_range_o <= 1'b0;
    end else if (out_tick) begin
      chan_a_result_o     <= encode_word(pack_out[28:15], gray_mode);
      chan_a_over_range_o <= pack_out[29];
      chan_b_result_o     <= encode_word(pack_out[13:0], gray_mode);
      chan_b_over_range_o <= pack_out[14];
    end
  end

  // Strobe rises a cycle after data settles, falls half a sample later
  logic strobe_set;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_set            <= 1'b0;
      sample_valid_strobe_o <= 1'b0;
    end else begin
      strobe_set <= out_tick;
      if (strobe_set) begin
        sample_valid_strobe_o <= 1'b1;
      end else if (!sclk_sync[1] || powered_down) begin
        sample_valid_strobe_o <= 1'b0;
      end
    end
  end

  // Wishbone slave: single-cycle ack, one cycle gap between answers
  logic       access;
  logic       hit;
  logic [2:0] status;
  logic [2:0] mask;
  logic       wr_status;
  assign access = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit = (adr_i == adc_port_pkg::STATUS_OFFSET) || (adr_i == adc_port_pkg::MASK_OFFSET)
            || (adr_i == adc_port_pkg::CONTROL_OFFSET) || (adr_i == adc_port_pkg::STATE_OFFSET);
  assign wr_status = access & we_i & sel_i[0] & (adr_i == adc_port_pkg::STATUS_OFFSET);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access & hit;
      err_o <= access & ~hit;
      dat_o <= 32'h0000_0000;
      if (access && !we_i) begin
        case (adr_i)
          adc_port_pkg::STATUS_OFFSET:  dat_o <= {29'h0, status};
          adc_port_pkg::MASK_OFFSET:    dat_o <= {29'h0, mask};
          adc_port_pkg::CONTROL_OFFSET: dat_o <= {30'h0, control};
          adc_port_pkg::STATE_OFFSET:   dat_o <= {28'h0, state, pd_sync[1], gray_sync[1]};
          default:                      dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask    <= adc_port_pkg::MASK_RESET;
      control <= adc_port_pkg::CONTROL_RESET;
    end else if (access && we_i && sel_i[0]) begin
      if (adr_i == adc_port_pkg::MASK_OFFSET) begin
        mask <= dat_i[2:0];
      end
      if (adr_i == adc_port_pkg::CONTROL_OFFSET) begin
        control <= dat_i[1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  logic [2:0] events;
  assign events = {out_tick, out_tick & pack_out[14], out_tick & pack_out[29]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= adc_port_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~(wr_status ? dat_i[2:0] : 3'h0)) | events;
    end
  end

  assign irq_o = |(status & mask);
endmodule

/* dual_adc_output_port_chk.sv */
// Port-level checker for the dual converter output port
`timescale 1ns/1ps
module dual_adc_output_port_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        power_down_input_i,
  input wire logic [13:0] chan_a_result_o,
  input wire logic        sample_valid_strobe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_down;
    power_down_input_i [*5];
  endsequence
  property p_ack; cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_err; err_o |=> !err_o && !ack_o; endproperty
  a_err: assert property (p_err) else $error("err longer than one cycle");
  property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_pd; s_down |-> !sample_valid_strobe_o; endproperty
  a_pd: assert property (p_pd) else $error("strobe while powered down");
  property p_setup; $rose(sample_valid_strobe_o) |-> $stable(chan_a_result_o); endproperty
  a_setup: assert property (p_setup) else $error("word moved at strobe");
  property p_hold; sample_valid_strobe_o && $past(sample_valid_strobe_o) |->
    $stable(chan_a_result_o); endproperty
  a_hold: assert property (p_hold) else $error("word moved under strobe");
  property p_gap;
    $rose(sample_valid_strobe_o) |=> (!$rose(sample_valid_strobe_o)) [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("strobes too close");
  property p_rst; disable iff (1'b0) rst_i |=> !sample_valid_strobe_o &&
    chan_a_result_o == 14'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind dual_adc_output_port dual_adc_output_port_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .power_down_input_i(power_down_input_i), .chan_a_result_o(chan_a_result_o),
  .sample_valid_strobe_o(sample_valid_strobe_o));

/* capture_model.sv */
// Back-end capture logic latching both channels on the strobe
`timescale 1ns/1ps
module capture_model (
  // Converter outputs
  input  wire logic        strobe_i,
  input  wire logic [13:0] a_i,
  input  wire logic [13:0] b_i,
  input  wire logic        ova_i,
  input  wire logic        ovb_i,
  // Captured sample
  output logic      [13:0] a_o,
  output logic      [13:0] b_o,
  output logic             ova_o,
  output logic             ovb_o,
  output int               count_o
);
  // Single driver for the capture count
  int count = 0;
  assign count_o = count;
  // Strobe used as the latch clock, as recommended
  always @(posedge strobe_i) begin
    a_o <= a_i;
    b_o <= b_i;
    ova_o <= ova_i;
    ovb_o <= ovb_i;
    count <= count + 1;
  end
endmodule

/* dual_adc_parallel_output_port_test.sv */
// Self-checking bench for the dual converter output port
`timescale 1ns/1ps
module dual_adc_parallel_output_port_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, scl = 0, gs = 0, pd = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic [13:0] ra = 14'h0, rb = 14'h0, cnt = 14'h0, a_o, b_o, ca, cb;
  logic        ova = 0, ovb = 0, ack_o, err_o, oa_o, ob_o, st_o, irq_o, coa, cob, e;
  logic [2:0]  ph = 3'h0;
  int          n_fail = 0, tests_run = 0, cap_n;

  dual_adc_output_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .sample_clk_i(scl), .chan_a_raw_i(ra), .chan_a_ovr_raw_i(ova),
    .chan_b_raw_i(rb), .chan_b_ovr_raw_i(ovb), .gray_select_i(gs),
    .power_down_input_i(pd), .chan_a_result_o(a_o), .chan_a_over_range_o(oa_o),
    .chan_b_result_o(b_o), .chan_b_over_range_o(ob_o), .sample_valid_strobe_o(st_o),
    .irq_o(irq_o));
  capture_model far (.strobe_i(st_o), .a_i(a_o), .b_i(b_o), .ova_i(oa_o), .ovb_i(ob_o),
    .a_o(ca), .b_o(cb), .ova_o(coa), .ovb_o(cob), .count_o(cap_n));

  initial forever #5 clk_i = ~clk_i;
  // Sampling clock of 16 cycles; raw data moves on its falling edge, well clear of sampling
  always @(posedge clk_i) begin
    ph <= ph + 3'h1;
    if (ph == 3'h7) begin
      scl <= ~scl;
      if (scl) begin
        ra <= cnt;
        rb <= ~cnt;
        ova <= cnt[0];
        ovb <= cnt[1];
      end else cnt <= cnt + 14'h1;
    end
  end

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r, output logic x);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    r = dat_o;
    x = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_cap();
    int k, n;
    k = cap_n;
    n = 0;
    while (cap_n == k && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 400) chk("capture", 32'h1, 32'h0);
  endtask

  task automatic t_regs();
    logic [7:0] m [3] = '{8'h00, 8'h04, 8'h08};
    foreach (m[i]) begin
      wb(1'b0, m[i], 32'h0, q, e);
      chk("reg_reset", 32'h0, q);
    end
    wb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    // Pipeline still filling this soon after reset
    wb(1'b0, 8'h0C, 32'h0, q, e);
    chk("state_fill", 32'h4, q);
    wb(1'b1, 8'h08, 32'h3, q, e);
    wb(1'b0, 8'h08, 32'h0, q, e);
    chk("control", 32'h3, q);
    wb(1'b0, 8'h0C, 32'h0, q, e);
    chk("state_down", 32'h0, q);
    wb(1'b1, 8'h08, 32'h0, q, e);
    $display("t_regs done");
  endtask

  // Output taken at a strobe came from the sample nine counts back
  task automatic t_stream(input logic g);
    logic [13:0] x, y;
    gs <= g;
    for (int i = 0; i < 4; i++) begin
      wait_cap();
      x = cnt - 14'h9;
      y = ~x;
      if (i > 0) begin
        chk("ovr_a", {31'h0, x[0]}, {31'h0, coa});
        chk("ovr_b", {31'h0, x[1]}, {31'h0, cob});
        if (g) begin
          x = x ^ (x >> 1);
          y = y ^ (y >> 1);
        end
        chk("word_a", {18'h0, x}, {18'h0, ca});
        chk("word_b", {18'h0, y}, {18'h0, cb});
      end
    end
    $display("t_stream %0d done", g);
  endtask

  task automatic t_pd_irq();
    int k;
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, 8'h04, 32'h4, q, e);
    wait_cap();
    repeat (3) @(posedge clk_i);
    chk("irq_set", 32'h1, {31'h0, irq_o});
    pd <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h7, q, e);
    k = cap_n;
    repeat (100) @(posedge clk_i);
    chk("irq_clear", 32'h0, {31'h0, irq_o});
    chk("no_capture", k, cap_n);
    pd <= 1'b0;
    $display("t_pd_irq done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_stream(1'b0);
    t_stream(1'b1);
    t_pd_irq();
    t_stream(1'b0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
